// *** rtl/qpc_pkg.sv ***
// constants, types and helpers shared by the quadrature position counter
`default_nettype none
package qpc_pkg;

   // ***************************
   // register byte addresses
   // ***************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_SCALE = 8'h0C;
   localparam logic [7:0] ADDR_OFFSET = 8'h10;
   localparam logic [7:0] ADDR_ANGLE = 8'h14;
   localparam logic [7:0] ADDR_LATCH = 8'h18;

   // ***************************
   // control field positions
   // ***************************
   localparam int CTRL_PREC_LSB = 0;
   localparam int CTRL_RST_EACH = 2;
   localparam int CTRL_RST_INV = 3;
   localparam int CTRL_EV_LSB = 4;
   localparam int CTRL_CNT_EN = 7;
   localparam int CTRL_SOFT_CLR = 8;
   localparam int CTRL_WIDTH = 8;

   // ***************************
   // status field positions
   // ***************************
   localparam int STAT_CNT_LVL = 0;
   localparam int STAT_DIR_LVL = 1;
   localparam int STAT_RST_LVL = 2;
   localparam int STAT_RST_ACT = 3;
   localparam int STAT_INVALID = 8;
   localparam int STAT_RST_SEEN = 9;

   // ***************************
   // reset values
   // ***************************
   localparam logic [7:0] CTRL_RESET = 8'h84;
   localparam logic [31:0] SCALE_RESET = 32'h0001_5753;
   localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
   localparam logic [31:0] FULL_TURN_UDEG = 32'h1575_2A00;

   // ***************************
   // types
   // ***************************
   typedef enum logic [1:0] {
      PREC_SINGLE,
      PREC_DOUBLE,
      PREC_QUAD
   } qpc_prec_type;

   // ***************************
   // byte-lane merge for writes
   // ***************************
   function automatic logic [31:0] qpc_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] sel
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage
`default_nettype wire

// *** rtl/qpc_sync.sv ***
// two-flop synchroniser for the encoder pins
`default_nettype none
module qpc_sync
   import qpc_pkg::*;
#(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // pins and synchronised levels
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // qpc_sync
`default_nettype wire

// *** rtl/qpc_scale.sv ***
// count to angle conversion, clamped to one revolution
`default_nettype none
module qpc_scale
   import qpc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // raw count and conversion settings
   input wire logic [31:0] count_i,
   input wire logic [31:0] scale_i,
   input wire logic [31:0] offset_i,
   // angle in microdegrees
   output logic [31:0] angle_o
);

   logic signed [32:0] scale_s;
   logic signed [64:0] prod_s;
   logic signed [64:0] sum_s;
   logic [31:0] angle_d;
   logic [31:0] angle_q;

   assign scale_s = $signed({1'b0, scale_i});
   assign prod_s = 65'($signed(count_i) * scale_s);
   assign sum_s = prod_s + $signed({{33{offset_i[31]}}, offset_i});
   // unipolar span: below zero pins at zero, above a turn pins at a turn
   assign angle_d = sum_s[64] ? 32'h0000_0000 :
                    (sum_s > $signed({33'h0_0000_0000, FULL_TURN_UDEG})) ?
                    FULL_TURN_UDEG : sum_s[31:0];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         angle_q <= '0;
      end else begin
         angle_q <= angle_d;
      end
   end

   assign angle_o = angle_q;

endmodule // qpc_scale
`default_nettype wire

// *** rtl/qpc_counter.sv ***
// quadrature position counter channel with wishbone register access
// How it works
// - three inputs: reset, direction, count; each also an event input.
// - quadrature mode follows transitions among the four combined phase states.
// - single precision counts only on count-input rising edges.
// - single precision is the default coupling after reset.
// - double precision counts both edges of the count input.
// - quad precision counts every edge of both inputs.
// - with per-pulse reset mode, each reset pulse clears the counter.
// - in per-pulse reset mode, reset input high clears to zero; inversion makes low active.
// - in per-pulse reset mode, counter holds zero while reset is active, resumes after release.
// - each input is visible as its own event output, individually enabled.
// - angle equals count times scale plus offset, scale default 87.891 millidegrees.
// - angle output spans zero to one full turn.
//
// Chosen here: the register offsets and the Wishbone register port.
`default_nettype none
module qpc_counter
   import qpc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // encoder pins
   input wire logic phase_a_input,
   input wire logic phase_b_input,
   input wire logic index_reset_input,
   // event channels
   output logic event_cnt_o,
   output logic event_dir_o,
   output logic event_rst_o,
   // position results
   output logic [31:0] count_o,
   output logic [31:0] angle_o
);

   // ***************************
   // pin synchronisation
   // ***************************
   logic [2:0] pins_sync;
   logic a_s;
   logic b_s;
   logic r_s;

   qpc_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin_i({index_reset_input, phase_b_input, phase_a_input}),
      .sync_o(pins_sync)
   );

   assign a_s = pins_sync[0];
   assign b_s = pins_sync[1];
   assign r_s = pins_sync[2];

   // ***************************
   // registers
   // ***************************
   logic [CTRL_WIDTH-1:0] ctrl_q;
   logic [CTRL_WIDTH-1:0] ctrl_d;
   logic [31:0] scale_q;
   logic [31:0] scale_d;
   logic [31:0] offset_q;
   logic [31:0] offset_d;
   logic [31:0] count_q;
   logic [31:0] count_d;
   logic [31:0] latch_q;
   logic invalid_q;
   logic rst_seen_q;
   logic soft_clr_q;
   logic a_prev_q;
   logic b_prev_q;
   logic rst_act_prev_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic ev_cnt_q;
   logic ev_dir_q;
   logic ev_rst_q;

   // ***************************
   // bus decode
   // ***************************
   logic bus_req;
   logic bus_wr;
   logic wr_ctrl;
   logic wr_status;
   logic wr_scale;
   logic wr_offset;
   logic [31:0] ctrl_wide;
   logic [31:0] status_word;
   logic [31:0] w1c_bits;

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign bus_wr = bus_req & wb_we_i;
   assign wr_ctrl = bus_wr & (wb_adr_i == ADDR_CTRL);
   assign wr_status = bus_wr & (wb_adr_i == ADDR_STATUS);
   assign wr_scale = bus_wr & (wb_adr_i == ADDR_SCALE);
   assign wr_offset = bus_wr & (wb_adr_i == ADDR_OFFSET);
   assign ctrl_wide = qpc_merge({24'h00_0000, ctrl_q}, wb_dat_i, wb_sel_i);
   assign w1c_bits = qpc_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

   assign ctrl_d = wr_ctrl ? ctrl_wide[CTRL_WIDTH-1:0] : ctrl_q;
   assign scale_d = wr_scale ? qpc_merge(scale_q, wb_dat_i, wb_sel_i) : scale_q;
   assign offset_d = wr_offset ? qpc_merge(offset_q, wb_dat_i, wb_sel_i) : offset_q;

   // ***************************
   // control fields
   // ***************************
   qpc_prec_type prec;
   logic rst_each;
   logic rst_inv;
   logic [2:0] ev_en;
   logic cnt_en;

   assign prec = qpc_prec_type'(ctrl_q[CTRL_PREC_LSB +: 2]);
   assign rst_each = ctrl_q[CTRL_RST_EACH];
   assign rst_inv = ctrl_q[CTRL_RST_INV];
   assign ev_en = ctrl_q[CTRL_EV_LSB +: 3];
   assign cnt_en = ctrl_q[CTRL_CNT_EN];

   // ***************************
   // reset input handling
   // ***************************
   logic rst_act;
   logic rst_hold;
   logic rst_rise;

   assign rst_act = r_s ^ rst_inv;
   assign rst_hold = rst_each & rst_act;
   assign rst_rise = rst_hold & ~rst_act_prev_q;

   // ***************************
   // quadrature decode
   // ***************************
   logic a_chg;
   logic b_chg;
   logic both_chg;
   logic a_rise;
   logic step_up;
   logic step_en;

   assign a_chg = a_s ^ a_prev_q;
   assign b_chg = b_s ^ b_prev_q;
   assign both_chg = a_chg & b_chg;
   assign a_rise = a_chg & a_s & ~b_chg;
   // a leading b walks 00,10,11,01: up when new a differs from old b
   assign step_up = a_s ^ b_prev_q;

   always_comb begin
      step_en = 1'b0;
      unique case (prec)
         PREC_DOUBLE: begin
            step_en = a_chg & ~b_chg;
         end
         PREC_QUAD: begin
            step_en = (a_chg ^ b_chg);
         end
         default: begin
            step_en = a_rise;
         end
      endcase
   end

   // ***************************
   // count update
   // ***************************
   logic count_step;

   assign count_step = cnt_en & step_en & ~both_chg;

   always_comb begin
      count_d = count_q;
      if (rst_hold) begin
         count_d = 32'h0000_0000;
      end else if (soft_clr_q) begin
         count_d = 32'h0000_0000;
      end else if (count_step) begin
         count_d = step_up ? count_q + 32'h0000_0001 : count_q - 32'h0000_0001;
      end
   end

   // ***************************
   // read data
   // ***************************
   assign status_word = {22'h00_0000, rst_seen_q, invalid_q, 4'h0, rst_act, r_s, b_s, a_s};

   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (wb_adr_i)
         ADDR_CTRL: rdata_d = {24'h00_0000, ctrl_q};
         ADDR_STATUS: rdata_d = status_word;
         ADDR_COUNT: rdata_d = count_q;
         ADDR_SCALE: rdata_d = scale_q;
         ADDR_OFFSET: rdata_d = offset_q;
         ADDR_ANGLE: rdata_d = angle_o;
         ADDR_LATCH: rdata_d = latch_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // ***************************
   // register processes
   // ***************************
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= CTRL_RESET;
         scale_q <= SCALE_RESET;
         offset_q <= OFFSET_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         scale_q <= scale_d;
         offset_q <= offset_d;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         soft_clr_q <= 1'b0;
      end else begin
         soft_clr_q <= wr_ctrl & ctrl_wide[CTRL_SOFT_CLR];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count_q <= '0;
         a_prev_q <= 1'b0;
         b_prev_q <= 1'b0;
         rst_act_prev_q <= 1'b0;
      end else begin
         count_q <= count_d;
         a_prev_q <= a_s;
         b_prev_q <= b_s;
         rst_act_prev_q <= rst_hold;
      end
   end

   // revolution count captured just before the reset clears it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         latch_q <= '0;
      end else if (rst_rise) begin
         latch_q <= count_q;
      end
   end

   // sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         invalid_q <= 1'b0;
         rst_seen_q <= 1'b0;
      end else begin
         invalid_q <= both_chg | (invalid_q & ~(wr_status & w1c_bits[STAT_INVALID]));
         rst_seen_q <= rst_rise | (rst_seen_q & ~(wr_status & w1c_bits[STAT_RST_SEEN]));
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= bus_req;
         rdata_q <= bus_req ? rdata_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ev_cnt_q <= 1'b0;
         ev_dir_q <= 1'b0;
         ev_rst_q <= 1'b0;
      end else begin
         ev_cnt_q <= a_s & ev_en[0];
         ev_dir_q <= b_s & ev_en[1];
         ev_rst_q <= r_s & ev_en[2];
      end
   end

   // ***************************
   // angle conversion
   // ***************************
   qpc_scale u_scale (
      .core_clk(core_clk),
      .resetn(resetn),
      .count_i(count_q),
      .scale_i(scale_q),
      .offset_i(offset_q),
      .angle_o(angle_o)
   );

   // ***************************
   // outputs
   // ***************************
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign count_o = count_q;
   assign event_cnt_o = ev_cnt_q;
   assign event_dir_o = ev_dir_q;
   assign event_rst_o = ev_rst_q;

endmodule // qpc_counter
`default_nettype wire

// *** verif/qpc_counter_assertions.sv ***
// port assertions for the quadrature position counter
`default_nettype none
module qpc_counter_chk
   import qpc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // pins
   input wire logic phase_a_input,
   input wire logic phase_b_input,
   input wire logic index_reset_input,
   // results
   input wire logic event_cnt_o,
   input wire logic event_dir_o,
   input wire logic event_rst_o,
   input wire logic [31:0] count_o,
   input wire logic [31:0] angle_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // ****
   // bus
   // ****
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   // ****
   // encoder
   // ****
   a_ev_count: assert property (event_cnt_o |-> $past(phase_a_input, 3))
      else $error("count event without pin");
   a_ev_dir: assert property (event_dir_o |-> $past(phase_b_input, 3))
      else $error("direction event without pin");
   a_ev_reset: assert property (event_rst_o |-> $past(index_reset_input, 3))
      else $error("reset event without pin");
   a_cnt_step: assert property ($changed(count_o) |-> count_o == 32'h0
      || count_o - $past(count_o) == 32'h1 || $past(count_o) - count_o == 32'h1)
      else $error("count jumped");
   a_cnt_cause: assert property ($changed(count_o) && count_o != 32'h0 |->
      $past(phase_a_input, 3) != $past(phase_a_input, 4)
      || $past(phase_b_input, 3) != $past(phase_b_input, 4))
      else $error("count moved without pin edge");
   a_angle_range: assert property (angle_o <= FULL_TURN_UDEG)
      else $error("angle above one turn");
   cover property (wb_ack_o);
   cover property (event_rst_o);
   cover property ($changed(count_o) && count_o != 32'h0);
endmodule // qpc_counter_chk

bind qpc_counter qpc_counter_chk i_qpc_counter_chk (.core_clk, .resetn, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .wb_dat_o, .phase_a_input, .phase_b_input, .index_reset_input,
   .event_cnt_o, .event_dir_o, .event_rst_o, .count_o, .angle_o);
`default_nettype wire

// *** verif/qpc_enc_model.sv ***
// encoder model: two phases a quarter period apart plus an index pulse
`default_nettype none
module qpc_enc_model (
   // clock and commands: 1 up, 2 down, 3 both phases at once
   input wire logic core_clk,
   input wire logic [1:0] cmd,
   input wire logic idx_req,
   // pins
   output logic phase_a,
   output logic phase_b,
   output logic index
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] st = 2'h0;
   logic [1:0] delta [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   assign phase_a = st[0] ^ st[1];
   assign phase_b = st[1];
   assign index = idx_req;
   always @(posedge core_clk) begin
      st <= st + delta[cmd];
   end
endmodule // qpc_enc_model
`default_nettype wire

// *** verif/tb_qpc_counter.sv ***
// self-checking bench for the quadrature position counter
`default_nettype none
module tb_qpc_counter
   import qpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic req = 1'b0;
   logic we = 1'b0;
   logic idx = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, off;
   logic ack, pa, pb, pr;
   logic ev_c, ev_d, ev_r;
   logic [31:0] cnt_o, ang_o;
   logic [31:0] expq[$];
   int err_count = 0;
   int n_tests = 0;
   int seed = 32'h61E45521;
   int n;

   always #4 core_clk = ~core_clk;

   qpc_enc_model i_qpc_enc_model (.core_clk, .cmd, .idx_req(idx), .phase_a(pa),
      .phase_b(pb), .index(pr));
   qpc_counter i_qpc_counter (.core_clk, .resetn, .wb_cyc_i(req), .wb_stb_i(req),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .phase_a_input(pa), .phase_b_input(pb), .index_reset_input(pr),
      .event_cnt_o(ev_c), .event_dir_o(ev_d), .event_rst_o(ev_r), .count_o(cnt_o),
      .angle_o(ang_o));

   // ****
   // tasks
   // ****
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack !== 1'b1 && k < 40);
      req <= 1'b0;
      if (ack !== 1'b1) begin
         err_count++;
         close_out;
      end
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   // pins hold each state long enough to be seen
   task automatic move(input int cnt, input logic [1:0] m);
      repeat (cnt) begin
         cmd <= m;
         @(posedge core_clk);
         cmd <= 2'h0;
         repeat (5) @(posedge core_clk);
      end
   endtask

   function automatic logic [31:0] mult(input int p);
      return (p == 1) ? 32'h2 : (p == 2) ? 32'h4 : 32'h1;
   endfunction

   always @(posedge core_clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         check(rdat, expq.pop_front());
      end
   end

   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rd(ADDR_CTRL, {24'h0, CTRL_RESET});
      rd(ADDR_SCALE, SCALE_RESET);
      rd(ADDR_OFFSET, OFFSET_RESET);
      rd(8'h1C, 32'h0);
      check({29'h0, ev_r, ev_d, ev_c}, 32'h0);
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, ADDR_CTRL, 32'h184 | 32'(p));
         move(8, 2'h1);
         rd(ADDR_COUNT, mult(p) << 1);
         move(8, 2'h2);
         rd(ADDR_COUNT, 32'h0);
      end
      n = ($random(seed) & 15) | 1;
      off = $random(seed) & 32'hFFFF;
      bus(1'b1, ADDR_CTRL, 32'h186);
      bus(1'b1, ADDR_OFFSET, off);
      move(n, 2'h1);
      rd(ADDR_COUNT, 32'(n));
      check(cnt_o, 32'(n));
      rd(ADDR_ANGLE, 32'(n) * SCALE_RESET + off);
      bus(1'b1, ADDR_SCALE, FULL_TURN_UDEG);
      rd(ADDR_ANGLE, FULL_TURN_UDEG);
      check(ang_o, FULL_TURN_UDEG);
      move(n + 1, 2'h2);
      rd(ADDR_ANGLE, 32'h0);
      move(1, 2'h3);
      rd(ADDR_COUNT, 32'hFFFF_FFFF);
      rd(ADDR_STATUS, 32'h101);
      bus(1'b1, ADDR_STATUS, 32'h100);
      rd(ADDR_STATUS, 32'h1);
      bus(1'b1, ADDR_CTRL, 32'h186);
      move(4, 2'h1);
      idx <= 1'b1;
      move(4, 2'h1);
      rd(ADDR_COUNT, 32'h0);
      rd(ADDR_LATCH, 32'h4);
      rd(ADDR_STATUS, 32'h20D);
      idx <= 1'b0;
      move(4, 2'h1);
      rd(ADDR_COUNT, 32'h4);
      bus(1'b1, ADDR_CTRL, 32'h8E);
      move(2, 2'h1);
      rd(ADDR_COUNT, 32'h0);
      idx <= 1'b1;
      bus(1'b1, ADDR_CTRL, 32'hFE);
      move(4, 2'h1);
      rd(ADDR_COUNT, 32'h4);
      rd(ADDR_CTRL, 32'hFE);
      check({29'h0, ev_r, ev_d, ev_c}, 32'h6);
      check(cnt_o, 32'h4);
      close_out;
   end
endmodule // tb_qpc_counter
`default_nettype wire
